/* File: rtl/sccp_pkg.sv */
package sccp_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PLL_SETTLE_US = 100;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
  localparam int WAKE_CYC = 2048;
  localparam int GLITCH_CYC = 8;
  localparam int XTAL_MIN_HZ = 1000000;
  localparam int XTAL_MAX_HZ = 30000000;
  localparam int PLL_IN_MIN_HZ = 10000000;
  localparam int PLL_IN_MAX_HZ = 25000000;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PLL_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLL_CFG_OFS = 8'h04;
  localparam logic [7:0] PLL_STAT_OFS = 8'h08;
  localparam logic [7:0] PWR_MODE_OFS = 8'h0c;
  localparam logic [7:0] PERIPH_PWR_OFS = 8'h10;
  localparam logic [7:0] PCLK_DIV_OFS = 8'h14;
  localparam logic [7:0] VEC_MAP_OFS = 8'h18;
  localparam logic [7:0] EXT_FLAG_OFS = 8'h1c;
  localparam logic [7:0] EXT_MODE_OFS = 8'h20;
  localparam logic [7:0] EXT_WAKE_OFS = 8'h24;
  localparam logic [7:0] RST_SRC_OFS = 8'h28;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_CONN_BIT = 1;
  localparam int PLL_LOCK_BIT = 2;
  localparam int PLL_INOK_BIT = 3;
  localparam int MSEL_LSB = 0;
  localparam int PSEL_LSB = 5;
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam logic [4:0] MSEL_RST = 5'h00;
  localparam logic [1:0] PSEL_RST = 2'h0;
  localparam logic [1:0] PDIV_QUARTER = 2'h0;
  localparam logic [1:0] PDIV_FULL = 2'h1;
  localparam logic [1:0] PDIV_HALF = 2'h2;
  localparam logic VEC_FLASH = 1'b0;

  typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE} sccp_state_e;

endpackage

/* File: rtl/sccp_sysctrl.sv */
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sccp_sysctrl #(
  parameter int NPERIPH = 16,
  parameter int NEXT = 9,
  parameter int NGRP = 4,
  parameter int OSC_HZ = 12000000,
  parameter int PLL_SETTLE = sccp_pkg::PLL_SETTLE_CYC
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Reset sources, readiness and interrupt inputs
  input wire logic rst_pin_n_in,
  input wire logic wdt_rst_in,
  input wire logic osc_ok_in,
  input wire logic flash_init_done_in,
  input wire logic irq_any_in,
  input wire logic [NEXT-1:0] ext_int_in,
  // Clock and reset control, vector map and interrupt outputs
  output logic osc_en_out,
  output logic pll_en_out,
  output logic [4:0] pll_mult_out,
  output logic [1:0] pll_div_out,
  output logic cpu_clk_from_pll_out,
  output logic cpu_core_clock_en_out,
  output logic core_rst_out,
  output logic pclk_en_out,
  output logic [NPERIPH-1:0] periph_clk_en_out,
  output logic vec_from_sram_out,
  output logic [NGRP-1:0] ext_irq_out
);
  import sccp_pkg::*;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  logic ack_ff;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic chip_rst;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
  assign wr = avs_write_in & ack_ff;
  assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------
  // Reset pin filter
  // ----------------------------------------
  logic [2:0] rpin_sync_ff;
  logic rpin_low_ff;
  logic [3:0] glitch_cnt_ff;
  logic pin_rst_ff;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rpin_sync_ff <= 3'h7;
      rpin_low_ff <= 1'b0;
    end else begin
      rpin_sync_ff <= {rpin_sync_ff[1:0], rst_pin_n_in};
      if (rpin_sync_ff[1] == rpin_sync_ff[2]) begin
        rpin_low_ff <= ~rpin_sync_ff[2];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      glitch_cnt_ff <= 4'h0;
      pin_rst_ff <= 1'b0;
    end else if (!rpin_low_ff) begin
      glitch_cnt_ff <= 4'h0;
      pin_rst_ff <= 1'b0;
    end else if (glitch_cnt_ff == 4'(GLITCH_CYC - 1)) begin
      pin_rst_ff <= 1'b1;
    end else begin
      glitch_cnt_ff <= glitch_cnt_ff + 4'h1;
    end
  end

  assign chip_rst = srst_in | pin_rst_ff | wdt_rst_in;

  logic [1:0] rst_src_ff;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      rst_src_ff <= 2'h0;
    end else begin
      rst_src_ff <= (rst_src_ff & ~((wr && avs_address_in == RST_SRC_OFS) ? (avs_writedata_in[1:0] & wmask[1:0]) : 2'h0))
                    | {wdt_rst_in, pin_rst_ff};
    end
  end

  // ----------------------------------------
  // Oscillator ready sync
  // ----------------------------------------
  logic [2:0] osc_sync_ff;
  logic osc_ok_ff;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      osc_sync_ff <= 3'h0;
      osc_ok_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_ok_in};
      if (osc_sync_ff[1] == osc_sync_ff[2]) begin
        osc_ok_ff <= osc_sync_ff[2];
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic pll_en_ff;
  logic pll_conn_ff;
  logic pll_lock_ff;
  logic [4:0] msel_ff;
  logic [1:0] psel_ff;
  logic [NPERIPH-1:0] pconp_ff;
  logic [1:0] pdiv_ff;
  logic vec_ff;
  logic [NEXT-1:0] ext_mode_ff;
  logic [NEXT-1:0] ext_wake_ff;
  logic [31:0] cfg_new;
  logic [31:0] ctl_new;
  logic pll_in_ok;

  // Oscillator must be in crystal range and PLL input range
  assign pll_in_ok = (OSC_HZ >= XTAL_MIN_HZ) && (OSC_HZ <= XTAL_MAX_HZ) &&
                     (OSC_HZ >= PLL_IN_MIN_HZ) && (OSC_HZ <= PLL_IN_MAX_HZ);
  assign cfg_new = merge({25'h0, psel_ff, msel_ff}, avs_writedata_in, wmask);
  assign ctl_new = merge({30'h0, pll_conn_ff, pll_en_ff}, avs_writedata_in, wmask);

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      pll_en_ff <= 1'b0;
      pll_conn_ff <= 1'b0;
      msel_ff <= MSEL_RST;
      psel_ff <= PSEL_RST;
    end else begin
      if (wr && avs_address_in == PLL_CTRL_OFS) begin
        pll_en_ff <= ctl_new[PLL_EN_BIT] & pll_in_ok;
        // Connect only a running, locked PLL
        if (!ctl_new[PLL_CONN_BIT] || !ctl_new[PLL_EN_BIT]) begin
          pll_conn_ff <= 1'b0;
        end else if (pll_en_ff && pll_lock_ff) begin
          pll_conn_ff <= 1'b1;
        end
      end
      if (wr && avs_address_in == PLL_CFG_OFS) begin
        msel_ff <= cfg_new[MSEL_LSB +: 5];
        psel_ff <= cfg_new[PSEL_LSB +: 2];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      pconp_ff <= {NPERIPH{1'b1}};
      pdiv_ff <= PDIV_QUARTER;
      vec_ff <= VEC_FLASH;
      ext_mode_ff <= {NEXT{1'b0}};
      ext_wake_ff <= {NEXT{1'b0}};
    end else if (wr) begin
      case (avs_address_in)
        PERIPH_PWR_OFS: pconp_ff <= NPERIPH'(merge(32'(pconp_ff), avs_writedata_in, wmask));
        PCLK_DIV_OFS: pdiv_ff <= 2'(merge(32'(pdiv_ff), avs_writedata_in, wmask));
        VEC_MAP_OFS: vec_ff <= 1'(merge(32'(vec_ff), avs_writedata_in, wmask));
        EXT_MODE_OFS: ext_mode_ff <= NEXT'(merge(32'(ext_mode_ff), avs_writedata_in, wmask));
        EXT_WAKE_OFS: ext_wake_ff <= NEXT'(merge(32'(ext_wake_ff), avs_writedata_in, wmask));
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // External interrupt inputs
  // ----------------------------------------
  logic [NEXT-1:0] ext_lvl;
  logic [NEXT-1:0] ext_rise;
  logic [NEXT-1:0] ext_flag_ff;
  logic [NEXT-1:0] ext_req;
  logic [NEXT-1:0] ext_clr;

  genvar gi;
  generate
    for (gi = 0; gi < NEXT; gi++) begin : g_ext
      logic [2:0] sync_ff;
      logic lvl_ff;
      always_ff @(posedge mclk_in) begin
        if (srst_in) begin
          sync_ff <= 3'h0;
          lvl_ff <= 1'b0;
        end else begin
          sync_ff <= {sync_ff[1:0], ext_int_in[gi]};
          if (sync_ff[1] == sync_ff[2]) begin
            lvl_ff <= sync_ff[2];
          end
        end
      end
      assign ext_lvl[gi] = lvl_ff;
      assign ext_rise[gi] = (sync_ff[1] == sync_ff[2]) & sync_ff[2] & ~lvl_ff;
    end
  endgenerate

  assign ext_clr = (wr && avs_address_in == EXT_FLAG_OFS) ? (avs_writedata_in[NEXT-1:0] & wmask[NEXT-1:0])
                                                         : {NEXT{1'b0}};

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      ext_flag_ff <= {NEXT{1'b0}};
    end else begin
      ext_flag_ff <= (ext_flag_ff & ~ext_clr) | (ext_rise & ext_mode_ff);
    end
  end

  assign ext_req = (ext_flag_ff & ext_mode_ff) | (ext_lvl & ~ext_mode_ff);

  always_comb begin
    ext_irq_out = {NGRP{1'b0}};
    for (int i = 0; i < NEXT; i++) begin
      ext_irq_out[i % NGRP] = ext_irq_out[i % NGRP] | ext_req[i];
    end
  end

  // ----------------------------------------
  // Power mode and wake-up timer
  // ----------------------------------------
  sccp_state_e state_ff;
  logic [11:0] wake_cnt_ff;
  logic wake_done;
  logic pd_wake;

  assign wake_done = osc_ok_ff && (wake_cnt_ff == 12'(WAKE_CYC - 1));
  assign pd_wake = |(ext_lvl & ext_wake_ff);

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      state_ff <= ST_BOOT;
    end else begin
      case (state_ff)
        ST_BOOT: if (wake_done && flash_init_done_in) begin
          state_ff <= ST_RUN;
        end
        ST_RUN: if (wr && avs_address_in == PWR_MODE_OFS && avs_byteenable_in[0]) begin
          if (avs_writedata_in[PDOWN_BIT]) begin
            state_ff <= ST_PDOWN;
          end else if (avs_writedata_in[IDLE_BIT]) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: if (irq_any_in || (|ext_req)) begin
          state_ff <= ST_RUN;
        end
        ST_PDOWN: if (pd_wake) begin
          state_ff <= ST_WAKE;
        end
        ST_WAKE: if (wake_done) begin
          state_ff <= ST_RUN;
        end
        default: state_ff <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (chip_rst || !osc_ok_ff || (state_ff != ST_BOOT && state_ff != ST_WAKE)) begin
      wake_cnt_ff <= 12'h000;
    end else if (!wake_done) begin
      wake_cnt_ff <= wake_cnt_ff + 12'h001;
    end
  end

  // ----------------------------------------
  // PLL lock
  // ----------------------------------------
  logic [31:0] lock_cnt_ff;

  always_ff @(posedge mclk_in) begin
    if (chip_rst || !pll_en_ff || state_ff == ST_PDOWN || (wr && avs_address_in == PLL_CFG_OFS)) begin
      lock_cnt_ff <= 32'h0;
      pll_lock_ff <= 1'b0;
    end else if (lock_cnt_ff == 32'(PLL_SETTLE - 1)) begin
      pll_lock_ff <= 1'b1;
    end else begin
      lock_cnt_ff <= lock_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------
  // Peripheral clock divider
  // ----------------------------------------
  logic [1:0] pdiv_cnt_ff;
  logic pclk_en_ff;
  logic [1:0] pdiv_top;

  assign pdiv_top = (pdiv_ff == PDIV_FULL) ? 2'h0 : (pdiv_ff == PDIV_HALF) ? 2'h1 : 2'h3;

  always_ff @(posedge mclk_in) begin
    if (chip_rst || state_ff == ST_PDOWN) begin
      pdiv_cnt_ff <= 2'h0;
      pclk_en_ff <= 1'b0;
    end else begin
      pclk_en_ff <= (pdiv_cnt_ff >= pdiv_top);
      pdiv_cnt_ff <= (pdiv_cnt_ff >= pdiv_top) ? 2'h0 : pdiv_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb begin
    rdata = 32'h0;
    case (avs_address_in)
      PLL_CTRL_OFS: rdata = {30'h0, pll_conn_ff, pll_en_ff};
      PLL_CFG_OFS: rdata = {25'h0, psel_ff, msel_ff};
      PLL_STAT_OFS: rdata = {28'h0, pll_in_ok, pll_lock_ff, cpu_clk_from_pll_out, pll_en_ff};
      PWR_MODE_OFS: rdata = {30'h0, state_ff == ST_PDOWN, state_ff == ST_IDLE};
      PERIPH_PWR_OFS: rdata = 32'(pconp_ff);
      PCLK_DIV_OFS: rdata = {30'h0, pdiv_ff};
      VEC_MAP_OFS: rdata = {31'h0, vec_ff};
      EXT_FLAG_OFS: rdata = 32'(ext_flag_ff);
      EXT_MODE_OFS: rdata = 32'(ext_mode_ff);
      EXT_WAKE_OFS: rdata = 32'(ext_wake_ff);
      RST_SRC_OFS: rdata = {30'h0, rst_src_ff};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && !ack_ff) begin
      avs_readdata_out <= rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign osc_en_out = (state_ff != ST_PDOWN);
  assign pll_en_out = pll_en_ff && (state_ff != ST_PDOWN);
  assign pll_mult_out = msel_ff;
  assign pll_div_out = psel_ff;
  assign cpu_clk_from_pll_out = pll_conn_ff & pll_lock_ff & pll_en_out;
  assign cpu_core_clock_en_out = (state_ff == ST_RUN);
  assign core_rst_out = (state_ff == ST_BOOT);
  assign pclk_en_out = pclk_en_ff;
  assign periph_clk_en_out = {NPERIPH{pclk_en_ff}} & pconp_ff;
  assign vec_from_sram_out = vec_ff;

endmodule
`default_nettype wire

/* File: testbench/sccp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sccp_core_model #(
  parameter int OSC_START = 40
) (
  input wire logic mclk_in,
  input wire logic osc_en_in,
  output logic osc_ok_out,
  output logic flash_done_out
);
  // ----------------------------------------
  // Oscillator start-up and flash readiness
  // ----------------------------------------
  int cnt;
  always_ff @(posedge mclk_in) begin
    cnt <= osc_en_in ? cnt + int'(cnt < OSC_START) : 0;
    osc_ok_out <= osc_en_in && cnt >= OSC_START;
  end
  assign flash_done_out = osc_ok_out;
endmodule
`default_nettype wire

/* File: testbench/sccp_sysctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sccp_sysctrl_props #(
  parameter int NPERIPH = 16,
  parameter int NEXT = 9,
  parameter int PLL_SETTLE = 20
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic rst_pin_n_in,
  input wire logic wdt_rst_in,
  input wire logic osc_ok_in,
  input wire logic flash_init_done_in,
  input wire logic [NEXT-1:0] ext_int_in,
  input wire logic osc_en_out,
  input wire logic pll_en_out,
  input wire logic cpu_clk_from_pll_out,
  input wire logic cpu_core_clock_en_out,
  input wire logic core_rst_out,
  input wire logic pclk_en_out,
  input wire logic [NPERIPH-1:0] periph_clk_en_out
);
  import sccp_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [11:0] osc_cnt_ff;
  logic [15:0] lock_cnt_ff;
  logic [4:0] wake_age_ff;
  logic cfg_wr;
  assign cfg_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == PLL_CFG_OFS;
  always_ff @(posedge mclk_in) begin
    osc_cnt_ff <= (srst_in || !osc_ok_in) ? 12'h000 : osc_cnt_ff + 12'(osc_cnt_ff != 12'hfff);
    lock_cnt_ff <= (!pll_en_out || cfg_wr) ? 16'h0000 : lock_cnt_ff + 16'(lock_cnt_ff != 16'hffff);
    wake_age_ff <= (srst_in || |ext_int_in || !rst_pin_n_in || wdt_rst_in) ? 5'h00
      : wake_age_ff + 5'(wake_age_ff != 5'h1f);
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pll_bypass: assert property (!pll_en_out |-> !cpu_clk_from_pll_out)
    else $error("core clock taken from a stopped pll");
  a_reset_pll_off: assert property ($fell(srst_in) |-> !pll_en_out && !cpu_clk_from_pll_out)
    else $error("pll not off after reset");
  a_lock_before_use: assert property ($rose(cpu_clk_from_pll_out) |-> lock_cnt_ff + 2 >= PLL_SETTLE)
    else $error("pll connected before lock");
  a_pdown_quiet: assert property (!osc_en_out ##1 !osc_en_out |-> !pll_en_out && !cpu_core_clock_en_out && !pclk_en_out)
    else $error("clock running in power-down");
  a_periph_gate: assert property (|periph_clk_en_out |-> pclk_en_out)
    else $error("peripheral clock without pclk tick");
  a_boot_halt: assert property (core_rst_out |-> !cpu_core_clock_en_out)
    else $error("core clock runs in reset");
  a_boot_release: assert property ($fell(core_rst_out) |-> osc_cnt_ff >= 12'h800 && flash_init_done_in)
    else $error("reset released early");
  a_wake_timer: assert property ($rose(cpu_core_clock_en_out) |-> osc_cnt_ff >= 12'h800)
    else $error("execution resumed before wake count");
  a_wdt_reset: assert property (wdt_rst_in |=> core_rst_out && !pll_en_out)
    else $error("watchdog did not reset");
  a_pdown_exit: assert property ($rose(osc_en_out) |-> wake_age_ff < 5'h14)
    else $error("power-down left without cause");
  c_pll_used: cover property ($rose(cpu_clk_from_pll_out));
  c_pdown: cover property ($fell(osc_en_out));
  c_idle: cover property ($fell(cpu_core_clock_en_out) && osc_en_out && !core_rst_out);
endmodule
bind sccp_sysctrl sccp_sysctrl_props #(.NPERIPH(NPERIPH), .NEXT(NEXT), .PLL_SETTLE(PLL_SETTLE))
  sccp_sysctrl_props_inst (.*);
`default_nettype wire

/* File: testbench/test_system_clock_reset_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_reset_power_ctrl;
  import sccp_pkg::*;
  localparam int SETTLE = 20;
  logic mclk_in = 1'h0;
  logic srst_in = 1'h1;
  logic avs_read_in = 1'h0;
  logic avs_write_in = 1'h0;
  logic rst_pin_n_in = 1'h1;
  logic wdt_rst_in = 1'h0;
  logic irq_any_in = 1'h0;
  logic [7:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [8:0] ext_int_in = 9'h000;
  logic [31:0] avs_readdata_out, rdat;
  logic avs_waitrequest_out, osc_ok_in, flash_init_done_in, osc_en_out, pll_en_out, pclk_en_out;
  logic cpu_clk_from_pll_out, cpu_core_clock_en_out, core_rst_out, vec_from_sram_out;
  logic [4:0] pll_mult_out, m;
  logic [1:0] pll_div_out;
  logic [15:0] periph_clk_en_out;
  logic [15:0] lfsr = 16'h0976;
  logic [3:0] ext_irq_out;
  int bad_count = 0;
  int check_count = 0;
  int mdl [int];
  int pexp [4] = '{4, 16, 8, 4};
  always #5 mclk_in = ~mclk_in;
  sccp_sysctrl #(.PLL_SETTLE(SETTLE)) sccp_sysctrl_inst (.*);
  sccp_core_model sccp_core_model_inst (.mclk_in(mclk_in), .osc_en_in(osc_en_out), .osc_ok_out(osc_ok_in),
    .flash_done_out(flash_init_done_in));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fail_out(input string w);
    bad_count++;
    $display("Error %s expected done seen timeout", w);
    wrap_up();
  endtask
  task automatic chk_val(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic done(input string t);
    $display("Test %s finished, mismatches %0d", t, bad_count);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    @(posedge mclk_in);
    for (n = 0; avs_waitrequest_out !== 1'h0; n++) begin
      if (n == 20) fail_out("bus");
      @(posedge mclk_in);
    end
    rdat = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
    chk_val("read", mdl[a], rdat);
  endtask
  task automatic rd_all();
    for (int a = 0; a < 48; a += 4) rd(8'(a));
  endtask
  task automatic mdl_reset(input int src);
    for (int a = 0; a < 48; a += 4) mdl[a] = 0;
    mdl[PLL_STAT_OFS] = 8;
    mdl[PERIPH_PWR_OFS] = 32'hffff;
    mdl[RST_SRC_OFS] = src;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int n = 0; s !== v; n++) begin
      if (n == lim) fail_out("wait");
      @(posedge mclk_in);
    end
  endtask
  task automatic pclk_rate(input int e);
    int c;
    c = 0;
    repeat (16) begin
      @(posedge mclk_in);
      c += int'(pclk_en_out === 1'h1);
    end
    chk_val("pclk", e, c);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk_in);
    srst_in <= 1'h0;
    @(posedge mclk_in);
    mdl_reset(0);
    rd_all();
    wait_for(core_rst_out, 1'h0, 3000);
    chk_val("boot", 32'h8, {cpu_core_clock_en_out, vec_from_sram_out, pll_en_out, cpu_clk_from_pll_out});
    pclk_rate(4);
    foreach (pexp[i]) begin
      wr(PCLK_DIV_OFS, i);
      pclk_rate(pexp[i]);
    end
    done("reset and divider");
    for (int i = 0; i < 4; i++) begin
      m = i == 0 ? 5'h00 : i == 3 ? 5'h1f : 5'(rnd());
      wr(PLL_CFG_OFS, {25'h0, 2'(i), m});
      chk_val("pll cfg", {i[1:0], m}, {pll_div_out, pll_mult_out});
    end
    wr(PLL_CFG_OFS, 32'h23);
    wr(PLL_CTRL_OFS, 32'h2);
    rd(PLL_CTRL_OFS);
    wr(PLL_CTRL_OFS, 32'h3);
    mdl[PLL_CTRL_OFS] = 1;
    rd(PLL_CTRL_OFS);
    repeat (SETTLE) @(posedge mclk_in);
    mdl[PLL_STAT_OFS] = 13;
    rd(PLL_STAT_OFS);
    wr(PLL_CTRL_OFS, 32'h3);
    chk_val("pll use", 32'h1, cpu_clk_from_pll_out);
    done("pll");
    mdl[PERIPH_PWR_OFS] = rnd();
    wr(PERIPH_PWR_OFS, mdl[PERIPH_PWR_OFS]);
    wr(PCLK_DIV_OFS, 32'h1);
    @(posedge mclk_in);
    chk_val("periph", mdl[PERIPH_PWR_OFS], periph_clk_en_out);
    avs_byteenable_in <= 4'h2;
    wr(PERIPH_PWR_OFS, 32'h0);
    avs_byteenable_in <= 4'hf;
    mdl[PERIPH_PWR_OFS] &= 32'h00ff;
    rd(PERIPH_PWR_OFS);
    wr(VEC_MAP_OFS, 32'h1);
    chk_val("vec", 32'h1, vec_from_sram_out);
    for (int i = 0; i < 9; i++) begin
      ext_int_in <= 9'(1 << i);
      repeat (6) @(posedge mclk_in);
      chk_val("ext level", 1 << (i % 4), ext_irq_out);
    end
    ext_int_in <= 9'h000;
    mdl[EXT_MODE_OFS] = 32'h100;
    wr(EXT_MODE_OFS, 32'h100);
    repeat (4) @(posedge mclk_in);
    ext_int_in <= 9'h100;
    repeat (2) @(posedge mclk_in);
    ext_int_in <= 9'h000;
    repeat (6) @(posedge mclk_in);
    chk_val("ext edge", 32'h1, ext_irq_out);
    mdl[EXT_FLAG_OFS] = 32'h100;
    rd(EXT_FLAG_OFS);
    wr(EXT_FLAG_OFS, 32'h100);
    mdl[EXT_FLAG_OFS] = 0;
    rd(EXT_FLAG_OFS);
    done("periph vec ext");
    wr(PCLK_DIV_OFS, 32'h2);
    wr(PWR_MODE_OFS, 32'h1);
    chk_val("idle", 32'h3, {cpu_core_clock_en_out, osc_en_out, pll_en_out});
    pclk_rate(8);
    irq_any_in <= 1'h1;
    wait_for(cpu_core_clock_en_out, 1'h1, 20);
    irq_any_in <= 1'h0;
    wr(EXT_WAKE_OFS, 32'h4);
    wr(PWR_MODE_OFS, 32'h3);
    @(posedge mclk_in);
    chk_val("pdown", 32'h0, {osc_en_out, pll_en_out, cpu_core_clock_en_out, pclk_en_out, cpu_clk_from_pll_out});
    ext_int_in <= 9'h001;
    repeat (10) @(posedge mclk_in);
    chk_val("no wake", 32'h0, osc_en_out);
    ext_int_in <= 9'h004;
    wait_for(cpu_core_clock_en_out, 1'h1, 3000);
    chk_val("wake rst", 32'h0, core_rst_out);
    ext_int_in <= 9'h000;
    rd(PERIPH_PWR_OFS);
    done("power modes");
    wdt_rst_in <= 1'h1;
    @(posedge mclk_in);
    wdt_rst_in <= 1'h0;
    @(posedge mclk_in);
    chk_val("wdt", 32'h2, {core_rst_out, pll_en_out});
    mdl_reset(2);
    rd_all();
    wait_for(core_rst_out, 1'h0, 3000);
    rst_pin_n_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    rst_pin_n_in <= 1'h1;
    repeat (20) @(posedge mclk_in);
    chk_val("glitch", 32'h0, core_rst_out);
    rst_pin_n_in <= 1'h0;
    repeat (30) @(posedge mclk_in);
    rst_pin_n_in <= 1'h1;
    @(posedge mclk_in);
    chk_val("pin rst", 32'h1, core_rst_out);
    mdl[RST_SRC_OFS] = 3;
    rd(RST_SRC_OFS);
    done("reset sources");
    wrap_up();
  end
endmodule
`default_nettype wire
